/* hdl/global_config_defines.svh */
// Purpose: offsets, field positions, reset values and widths of the chip-level configuration bank
// Assumes: indices are the full 8-bit value written to the index port
// Notes:   included by its bare name; definitions only
`ifndef GLOBAL_CONFIG_DEFINES_SVH
`define GLOBAL_CONFIG_DEFINES_SVH

`define GCR_IDX_W            8                 // index port width
`define GCR_DATA_W           8                 // data port width
`define GCR_IDX_CFG_CONTROL  8'h02             // soft-reset trigger, write only
`define GCR_IDX_FUNC_SELECT  8'h07             // current logical device
`define GCR_IDX_CHIP_ID      8'h20             // identification code, read only
`define GCR_IDX_CHIP_REV     8'h21             // revision code, read only
`define GCR_IDX_GLOBAL_LAST  8'h2F             // last index of the global bank
`define GCR_IDX_ACTIVATE     8'h30             // per-device activate register
`define GCR_SOFT_RESET_BIT   0                 // trigger bit in config_control
`define GCR_ACTIVATE_BIT     0                 // enable bit in activate register
`define GCR_RST_FUNC_SELECT  8'h00             // function_select reset value
`define GCR_RST_CFG_CONTROL  8'h00             // config_control reset value
`define GCR_ZERO             8'h00             // reserved indices and bits read as this

`endif

/* hdl/global_config_pkg.sv */
// Purpose: types shared by the chip-level configuration bank
// Assumes: constants live in global_config_defines.svh
// Notes:   nothing here is imported; use global_config_pkg::name
package global_config_pkg;

    // which of the two host ports an access addresses
    typedef enum logic
    {
        PORT_INDEX = 1'b0,                      // index port selects a register
        PORT_DATA  = 1'b1                       // data port reaches the selected register
    } port_sel_t;

endpackage : global_config_pkg

/* hdl/global_config_registers.sv */
// Purpose: chip-level configuration bank reached through an index port and a data port
// Assumes: port strobes and cfgModeActive come from logic on ref_clk; arst_n is the power-on reset
// Notes:   read data appears one cycle after the read strobe, together with rdValid_ff
`timescale 1ns/100ps
`include "global_config_defines.svh"

module global_config_registers #(
    parameter int             NUM_FUNCS = 12,       // logical devices that own an activate bit
    parameter logic [7:0]     CHIP_ID   = 8'hA5,    // arbitrary identification value
    parameter logic [7:0]     CHIP_REV  = 8'h01     // arbitrary revision value
) (
    // clock and resets
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    input  wire logic                    standbyPorRst_n,
    input  wire logic                    busReset,
    // configuration mode from the entry-sequence logic
    input  wire logic                    cfgModeActive,
    // host port access
    input  wire logic                    portWrite,
    input  wire logic                    portRead,
    input  wire global_config_pkg::port_sel_t portSel,
    input  wire logic [`GCR_DATA_W-1:0]  portWrData,
    output logic      [`GCR_DATA_W-1:0]  rdData_ff,
    output logic                         rdValid_ff,
    // chip-level state to the logical devices
    output logic      [`GCR_DATA_W-1:0]  functionSel_ff,
    output logic                         softResetPulse_ff,
    output logic      [NUM_FUNCS-1:0]    activeFlags_ff
);

    // elaboration check: select value must be able to name every device
    if (NUM_FUNCS < 1 || NUM_FUNCS > 256)
    begin : g_bad_num_funcs
        $error("NUM_FUNCS must lie between 1 and 256");
    end

    // reset synchroniser state
    logic       rstMeta_ff;                     // first stage, read only by the second
    logic       rstSync_ff;                     // released reset, active high means running
    logic       arstAll_n;                      // main and standby power-on resets combined

    assign arstAll_n = arst_n & standbyPorRst_n;

    // release reset through two flip-flops
    always_ff @(posedge ref_clk or negedge arstAll_n)
    begin
        if (!arstAll_n)
        begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end
        else
        begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    // register state and next values
    logic [`GCR_IDX_W-1:0]   index_ff;          // register selected by the index port
    logic [`GCR_IDX_W-1:0]   nxt_index;
    logic [`GCR_DATA_W-1:0]  nxt_functionSel;
    logic                    nxt_softResetPulse;
    logic [NUM_FUNCS-1:0]    nxt_activeFlags;
    logic [`GCR_DATA_W-1:0]  nxt_rdData;
    logic                    nxt_rdValid;
    logic                    idxWr;             // accepted index write
    logic                    dataWr;            // accepted data write
    logic                    dataRd;            // accepted data read
    logic                    softTrig;          // trigger bit written as one
    logic [`GCR_DATA_W-1:0]  dataView;          // value the selected register shows
    logic [NUM_FUNCS-1:0]    selOneHot;         // decoded current device

    // strobes are honoured only in configuration mode
    assign idxWr  = portWrite & cfgModeActive & (portSel == global_config_pkg::PORT_INDEX);
    assign dataWr = portWrite & cfgModeActive & (portSel == global_config_pkg::PORT_DATA);
    assign dataRd = portRead  & cfgModeActive & (portSel == global_config_pkg::PORT_DATA);
    assign softTrig = dataWr & (index_ff == `GCR_IDX_CFG_CONTROL)
                      & portWrData[`GCR_SOFT_RESET_BIT];

    // one enable per logical device, set when the select register names it
    localparam int DW = `GCR_DATA_W;            // select value width for the device compare
    genvar gi;
    for (gi = 0; gi < NUM_FUNCS; gi++)
    begin : g_sel
        assign selOneHot[gi] = (functionSel_ff == DW'(gi));
    end

    // read view of the selected register; everything else reads zero
    always_comb
    begin
        unique case (index_ff)
            `GCR_IDX_FUNC_SELECT: dataView = functionSel_ff;
            `GCR_IDX_CHIP_ID:     dataView = CHIP_ID;
            `GCR_IDX_CHIP_REV:    dataView = CHIP_REV;
            `GCR_IDX_ACTIVATE:    dataView = {7'h00, |(activeFlags_ff & selOneHot)};
            default:              dataView = `GCR_ZERO;
        endcase
    end

    // next values of the bank
    always_comb
    begin
        nxt_index          = index_ff;
        nxt_functionSel    = functionSel_ff;
        nxt_activeFlags    = activeFlags_ff;
        nxt_softResetPulse = softTrig;
        nxt_rdValid        = portRead & cfgModeActive;
        nxt_rdData         = `GCR_ZERO;
        // index write selects the register for later data accesses
        if (idxWr)
        begin
            nxt_index = portWrData;
        end
        // data write goes to the indexed register only
        if (dataWr)
        begin
            if (index_ff == `GCR_IDX_FUNC_SELECT)
            begin
                nxt_functionSel = portWrData;
            end
            if (index_ff == `GCR_IDX_ACTIVATE)
            begin
                // only the current device's bit changes
                nxt_activeFlags = (activeFlags_ff & ~selOneHot)
                    | (selOneHot & {NUM_FUNCS{portWrData[`GCR_ACTIVATE_BIT]}});
            end
        end
        // soft reset loads select and activates with their soft-reset values
        if (softTrig)
        begin
            nxt_functionSel = `GCR_RST_FUNC_SELECT;
            nxt_activeFlags = '0;
        end
        // reads: index port returns the index, data port the selected register
        if (portRead & cfgModeActive)
        begin
            nxt_rdData = (portSel == global_config_pkg::PORT_INDEX) ? index_ff : dataView;
        end
    end

    // register the bank; bus reset acts as a synchronous clear
    always_ff @(posedge ref_clk or negedge arstAll_n)
    begin
        if (!arstAll_n)
        begin
            index_ff          <= `GCR_ZERO;
            functionSel_ff    <= `GCR_RST_FUNC_SELECT;
            softResetPulse_ff <= 1'b0;
            activeFlags_ff    <= '0;
            rdData_ff         <= `GCR_ZERO;
            rdValid_ff        <= 1'b0;
        end
        else if (!rstSync_ff || busReset)
        begin
            index_ff          <= `GCR_ZERO;
            functionSel_ff    <= `GCR_RST_FUNC_SELECT;
            softResetPulse_ff <= 1'b0;
            activeFlags_ff    <= '0;
            rdData_ff         <= `GCR_ZERO;
            rdValid_ff        <= 1'b0;
        end
        else
        begin
            index_ff          <= nxt_index;
            functionSel_ff    <= nxt_functionSel;
            softResetPulse_ff <= nxt_softResetPulse;
            activeFlags_ff    <= nxt_activeFlags;
            rdData_ff         <= nxt_rdData;
            rdValid_ff        <= nxt_rdValid;
        end
    end

    // checks on the bank
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arstAll_n || !rstSync_ff || busReset);

    chk_blocked_read_zero: assert property (portRead && !cfgModeActive |=> rdData_ff == 8'h00 && !rdValid_ff)
        else $error("read outside configuration mode returned data");
    chk_blocked_write_kept: assert property (portWrite && !cfgModeActive |=> $stable(functionSel_ff) && $stable(index_ff))
        else $error("write outside configuration mode changed state");
    chk_reserved_read_zero: assert property (dataRd && index_ff inside {[8'h00:8'h01], [8'h03:8'h06], [8'h08:8'h1F],
        [8'h22:8'h2F]} |=> rdData_ff == 8'h00)
        else $error("reserved index read nonzero");
    chk_control_reads_zero: assert property (dataRd && index_ff == 8'h02 |=> rdData_ff == 8'h00)
        else $error("write-only control register read nonzero");
    chk_alias_free: assert property (dataRd && index_ff == 8'hA0 |=> rdData_ff == 8'h00)
        else $error("upper index bits aliased onto identification register");
    chk_id_value: assert property (dataRd && index_ff == 8'h20 |=> rdData_ff == CHIP_ID && rdValid_ff)
        else $error("identification code wrong");
    chk_rev_value: assert property (dataRd && index_ff == 8'h21 |=> rdData_ff == CHIP_REV)
        else $error("revision code wrong");
    chk_soft_reset_pulse: assert property (softTrig |=> softResetPulse_ff && functionSel_ff == 8'h00
        ##1 !softResetPulse_ff || $past(softTrig))
        else $error("soft reset did not clear select or trigger stuck");
    chk_trigger_selfclear: assert property (softResetPulse_ff && !softTrig |=> !softResetPulse_ff)
        else $error("soft-reset trigger did not clear itself");
    chk_select_write: assert property (dataWr && index_ff == 8'h07 && !softTrig |=> functionSel_ff == $past(portWrData))
        else $error("select register not written");
    chk_activate_other: assert property (dataWr && index_ff == 8'h30 |=> (activeFlags_ff & ~$past(selOneHot))
        == ($past(activeFlags_ff) & ~$past(selOneHot)))
        else $error("activate changed an unselected device");
    chk_index_readback: assert property (idxWr ##1 portRead && cfgModeActive && portSel == global_config_pkg::PORT_INDEX
        |=> rdData_ff == $past(portWrData, 2))
        else $error("index port did not hold written index");

    cov_soft_reset:  cover property (softTrig ##1 softResetPulse_ff);
    cov_id_read:     cover property (idxWr && portWrData == 8'h20 ##2 dataRd);
    cov_activate:    cover property (dataWr && index_ff == 8'h30 && portWrData[0]);
    cov_blocked:     cover property (portWrite && !cfgModeActive);

endmodule : global_config_registers

/* test/global_config_registers_test.sv */
// Purpose: self-checking bench for the chip-level configuration bank
// Assumes: inputs change on the falling edge of ref_clk; registered outputs are settled by then
// Notes:   ordinary indices run from a table; resets, refusal, activate and soft reset follow by hand
`timescale 1ns/100ps
`include "global_config_defines.svh"

module global_config_registers_test;
    localparam logic [7:0] ID_VAL  = 8'h3C;                // arbitrary identification value
    localparam logic [7:0] REV_VAL = 8'h07;                // arbitrary revision value
    localparam int         NF      = 12;                   // logical devices in the bench
    // stimulus and observed outputs
    logic                         ref_clk, arst_n, standbyPorRst_n, busReset, cfgModeActive;
    logic                         portWrite, portRead, rdValid_ff, softResetPulse_ff;
    global_config_pkg::port_sel_t portSel;
    logic [7:0]                   portWrData, rdData_ff, functionSel_ff;
    logic [NF-1:0]                activeFlags_ff;
    int                           error_cnt = 0;           // mismatches seen
    int                           tests_run = 0;           // comparisons made
    int                           pulseSeen;               // soft-reset pulse count
    // table rows: index, data written, value read back
    logic [7:0] rowIdx [12] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h1F, 8'h2F, 8'h20, 8'h21, 8'h87, 8'hA0};
    logic [7:0] rowDat [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hAA, 8'h5A};
    logic [7:0] rowExp [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, ID_VAL, REV_VAL, 8'h00, 8'h00};

    global_config_registers #(.NUM_FUNCS(NF), .CHIP_ID(ID_VAL), .CHIP_REV(REV_VAL)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .standbyPorRst_n(standbyPorRst_n), .busReset(busReset),
        .cfgModeActive(cfgModeActive), .portWrite(portWrite), .portRead(portRead), .portSel(portSel),
        .portWrData(portWrData), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
        .functionSel_ff(functionSel_ff), .softResetPulse_ff(softResetPulse_ff),
        .activeFlags_ff(activeFlags_ff));

    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // compare one value, report and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one write strobe, then an idle cycle so strobes never touch
    task automatic put(input global_config_pkg::port_sel_t sel, input logic [7:0] d);
        portSel    = sel;
        portWrData = d;
        portWrite  = 1'b1;
        @(negedge ref_clk);
        portWrite  = 1'b0;
        @(negedge ref_clk);
    endtask : put

    // one read strobe; answer is looked at in the single cycle it stands
    task automatic get(input global_config_pkg::port_sel_t sel, input logic [7:0] exp, input logic vld);
        portSel  = sel;
        portRead = 1'b1;
        @(negedge ref_clk);
        portRead = 1'b0;
        chk({7'h00, rdValid_ff}, {7'h00, vld});
        chk(rdData_ff, exp);
        @(negedge ref_clk);
    endtask : get

    // verdict and end of run
    task automatic finish_test;
        $display("checks=%0d errors=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // watchdog cuts a hang short
    initial
    begin
        #(25.0 * 3000);
        error_cnt++;
        finish_test();
    end

    // main sequence
    initial
    begin
        {arst_n, busReset, portWrite, portRead} = 4'h0;
        {standbyPorRst_n, cfgModeActive}        = 2'h3;
        portSel    = global_config_pkg::PORT_INDEX;
        portWrData = 8'h00;
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(functionSel_ff, 8'h00);
        chk({7'h00, softResetPulse_ff}, 8'h00);
        chk(rdData_ff, 8'h00);
        chk(activeFlags_ff[7:0], 8'h00);
        // table of ordinary indices
        for (int i = 0; i < 12; i++)
        begin
            put(global_config_pkg::PORT_INDEX, rowIdx[i]);
            put(global_config_pkg::PORT_DATA, rowDat[i]);
            get(global_config_pkg::PORT_DATA, rowExp[i], 1'b1);
        end
        // back to back: index write, index read, data read on consecutive edges
        portSel    = global_config_pkg::PORT_INDEX;
        portWrData = `GCR_IDX_CHIP_REV;
        portWrite  = 1'b1;
        @(negedge ref_clk);
        portWrite  = 1'b0;
        portRead   = 1'b1;
        @(negedge ref_clk);
        portSel    = global_config_pkg::PORT_DATA;
        chk(rdData_ff, `GCR_IDX_CHIP_REV);
        @(negedge ref_clk);
        portRead   = 1'b0;
        chk(rdData_ff, REV_VAL);
        chk({7'h00, rdValid_ff}, 8'h01);
        @(negedge ref_clk);
        // upper-bit aliases left the select value alone; index port reads back
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT);
        get(global_config_pkg::PORT_DATA, 8'h05, 1'b1);
        get(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT, 1'b1);
        // outside configuration mode nothing is taken, index included
        cfgModeActive = 1'b0;
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_CHIP_ID);
        put(global_config_pkg::PORT_DATA, 8'h09);
        get(global_config_pkg::PORT_DATA, 8'h00, 1'b0);
        cfgModeActive = 1'b1;
        chk(functionSel_ff, 8'h05);
        // a refused index write would send this to the identification register
        put(global_config_pkg::PORT_DATA, 8'h03);
        chk(functionSel_ff, 8'h03);
        // activate touches the selected device only
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_ACTIVATE);
        put(global_config_pkg::PORT_DATA, 8'h01);
        chk(activeFlags_ff[7:0], 8'h08);
        chk({4'h0, activeFlags_ff[11:8]}, 8'h00);
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT);
        put(global_config_pkg::PORT_DATA, 8'h05);
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_ACTIVATE);
        put(global_config_pkg::PORT_DATA, 8'h01);
        chk(activeFlags_ff[7:0], 8'h28);
        get(global_config_pkg::PORT_DATA, 8'h01, 1'b1);
        put(global_config_pkg::PORT_DATA, 8'h00);
        chk(activeFlags_ff[7:0], 8'h08);
        get(global_config_pkg::PORT_DATA, 8'h00, 1'b1);
        // soft reset: clears select and activates, pulse once, trigger reads back zero
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_CFG_CONTROL);
        portSel    = global_config_pkg::PORT_DATA;
        portWrData = 8'h01;
        portWrite  = 1'b1;
        @(negedge ref_clk);
        portWrite  = 1'b0;
        pulseSeen  = int'(softResetPulse_ff === 1'b1);
        chk(functionSel_ff, 8'h00);
        @(negedge ref_clk);
        pulseSeen += int'(softResetPulse_ff === 1'b1);
        chk(8'(pulseSeen), 8'h01);
        chk(activeFlags_ff[7:0], 8'h00);
        @(negedge ref_clk);
        chk({7'h00, softResetPulse_ff}, 8'h00);
        get(global_config_pkg::PORT_DATA, 8'h00, 1'b1);
        // bus reset clears the select register
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT);
        put(global_config_pkg::PORT_DATA, 8'h06);
        chk(functionSel_ff, 8'h06);
        busReset = 1'b1;
        @(negedge ref_clk);
        busReset = 1'b0;
        chk(functionSel_ff, 8'h00);
        // standby power-on reset clears it too; bus reset also cleared the index
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT);
        put(global_config_pkg::PORT_DATA, 8'h06);
        chk(functionSel_ff, 8'h06);
        standbyPorRst_n = 1'b0;
        @(negedge ref_clk);
        chk(functionSel_ff, 8'h00);
        standbyPorRst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        put(global_config_pkg::PORT_INDEX, `GCR_IDX_FUNC_SELECT);
        get(global_config_pkg::PORT_DATA, 8'h00, 1'b1);
        finish_test();
    end
endmodule : global_config_registers_test
